// [node_cfg.svh]
// constants for the canopen node: identifiers, node states, protocol codes, timing
// assumes a 100 MHz system clock and 11-bit base-format identifiers
`ifndef NODE_CFG_SVH
`define NODE_CFG_SVH

`define CLK_KHZ 100000
`define TQ_PER_BIT 10
`define RATE_125K 125
`define RATE_250K 250
`define RATE_500K 500
`define RATE_1000K 1000
`define HB_PERIOD_MS 1000

`define SW_RATE_LSB 0
`define SW_ID_LSB 2

`define COB_NMT 11'h000
`define COB_EMCY 11'h080
`define COB_SDO_TX 11'h580
`define COB_SDO_RX 11'h600
`define COB_HB 11'h700

`define ST_BOOT 8'h00
`define ST_STOPPED 8'h04
`define ST_OPER 8'h05
`define ST_PREOP 8'h7f

`define NMT_START 8'h01
`define NMT_STOP 8'h02
`define NMT_PREOP 8'h80
`define NMT_RESET_APP 8'h81
`define NMT_RESET_COMM 8'h82

`define CCS_DOWNLOAD 3'h1
`define CCS_UPLOAD 3'h2
`define SCS_DOWNLOAD_OK 8'h60
`define SCS_UPLOAD_4B 8'h43
`define SCS_ABORT 8'h80
`define ABORT_BAD_CMD 32'h05040001
`define EXPEDITED_BIT 1
`define DLC_FULL 4'h8
`define DLC_HB 4'h1

`endif

// [node_pkg.sv]
// types shared by the canopen node modules
// assumes node_cfg.svh for the numeric constants
package node_pkg;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'b000,
    FSM_OD = 3'b001,
    FSM_TX = 3'b010
  } fsm_t;

  typedef enum logic [1:0] {
    TXK_SDO = 2'b00,
    TXK_EMCY = 2'b01,
    TXK_HB = 2'b10
  } tx_kind_t;

  typedef struct packed {
    logic loaded;
    logic [5:0] node_id;
    logic [1:0] rate_sel;
  } cfg_state_t;

endpackage

// [node_cfg_if.sv]
// carries the captured switch configuration from the decoder to the node
// assumes a single clock domain
`timescale 1ns/1ps
interface node_cfg_if;
  logic valid;
  logic [5:0] node_id;
  logic [1:0] rate_sel;
  modport src(output valid, output node_id, output rate_sel);
  modport dst(input valid, input node_id, input rate_sel);
endinterface

// [dip_config.sv]
// decodes the eight-position configuration switch into bit rate and node id
// assumes switch inputs already synchronous to sys_clk; pin is low when pushed down
`timescale 1ns/1ps
`include "node_cfg.svh"
module dip_config (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] dip_sw_n,
  node_cfg_if.src cfg
);
  node_pkg::cfg_state_t state_r;
  node_pkg::cfg_state_t state_nxt;
  logic [7:0] sw_down;

  assign sw_down = ~dip_sw_n; // down reads as one [RULE3]

  // captured once after reset release, later switch moves are ignored
  always_comb begin
    state_nxt = state_r;
    if (!state_r.loaded) begin // [RULE7]
      state_nxt.loaded = 1'b1;
      // position 1 is the high bit of the rate code
      state_nxt.rate_sel = {sw_down[`SW_RATE_LSB], sw_down[`SW_RATE_LSB + 1]}; // [RULE1]
      // position 3 is the high bit of the id
      state_nxt.node_id = {sw_down[`SW_ID_LSB], sw_down[`SW_ID_LSB + 1],
                           sw_down[`SW_ID_LSB + 2], sw_down[`SW_ID_LSB + 3],
                           sw_down[`SW_ID_LSB + 4], sw_down[`SW_ID_LSB + 5]}; // [RULE2]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign cfg.valid = state_r.loaded;
  assign cfg.node_id = state_r.node_id;
  assign cfg.rate_sel = state_r.rate_sel;
endmodule

// [canopen_node.sv]
// canopen slave node logic: network management, heartbeat, emergency, expedited sdo
// assumes an external can controller moving whole frames; object dictionary outside
// Notes on behaviour
// (RULE1) switch positions 1-2 pick the bit rate
// (RULE2) positions 3-8 give six-bit node id
// (RULE3) switch down reads one, up zero
// (RULE4) heartbeat with node state sent periodically
// (RULE5) error event sends an emergency message
// (RULE6) sdo expedited only, four bytes maximum
// (RULE7) configuration latched at reset, then frozen
`timescale 1ns/1ps
`include "node_cfg.svh"
module canopen_node #(
  parameter int HB_CYCLES = `HB_PERIOD_MS * `CLK_KHZ
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] dip_sw_n,
  output logic [5:0] node_id,
  output logic [1:0] bit_rate_sel,
  output logic [7:0] bit_div,
  output logic [7:0] nmt_state,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [10:0] tx_id,
  output logic [3:0] tx_dlc,
  output logic [63:0] tx_data,
  input wire logic err_event,
  input wire logic [15:0] err_code,
  input wire logic [7:0] err_reg,
  output logic od_req,
  output logic od_write,
  output logic [15:0] od_index,
  output logic [7:0] od_sub,
  output logic [31:0] od_wdata,
  input wire logic od_ack,
  input wire logic od_fail,
  input wire logic [31:0] od_rdata
);
  typedef struct packed {
    node_pkg::fsm_t fsm;
    node_pkg::tx_kind_t kind;
    logic [7:0] nmt;
    logic [31:0] hb_cnt;
    logic hb_pend;
    logic emcy_pend;
    logic [15:0] emcy_code;
    logic [7:0] emcy_reg;
    logic od_write;
    logic [15:0] od_index;
    logic [7:0] od_sub;
    logic [31:0] od_wdata;
    logic [10:0] tx_id;
    logic [3:0] tx_dlc;
    logic [63:0] tx_data;
    logic [7:0] bit_div;
  } node_state_t;

  node_state_t state_r;
  node_state_t state_nxt;
  node_cfg_if cfg_bus();

  dip_config u_cfg (
    .sys_clk(sys_clk),
    .rst(rst),
    .dip_sw_n(dip_sw_n),
    .cfg(cfg_bus)
  );

  // timing divider per bit rate code, 10 time quanta per bit
  function automatic logic [7:0] rate_div(input logic [1:0] sel);
    int kbps;
    case (sel)
      2'h0: kbps = `RATE_125K;
      2'h1: kbps = `RATE_250K;
      2'h2: kbps = `RATE_500K;
      default: kbps = `RATE_1000K;
    endcase
    rate_div = 8'(`CLK_KHZ / (kbps * `TQ_PER_BIT)); // [RULE1]
  endfunction

  function automatic logic [10:0] cob(input logic [10:0] base, input logic [5:0] id);
    cob = base + {5'h00, id};
  endfunction

  function automatic logic [63:0] sdo_frame(input logic [7:0] cmd, input logic [15:0] idx,
                                            input logic [7:0] sub, input logic [31:0] val);
    sdo_frame = {val, sub, idx[15:8], idx[7:0], cmd};
  endfunction

  logic [2:0] rx_ccs;
  logic rx_is_nmt;
  logic rx_is_sdo;
  logic nmt_for_me;

  assign rx_ccs = rx_data[7:5];
  assign rx_is_nmt = (rx_id == `COB_NMT) && (rx_dlc >= 4'h2);
  assign rx_is_sdo = (rx_id == cob(`COB_SDO_RX, cfg_bus.node_id)) && (rx_dlc == `DLC_FULL);
  assign nmt_for_me = (rx_data[15:8] == 8'h00) || (rx_data[15:8] == {2'h0, cfg_bus.node_id});

  always_comb begin
    state_nxt = state_r;
    state_nxt.bit_div = rate_div(cfg_bus.rate_sel);
    // heartbeat timer runs in every state but boot-up
    if (state_r.nmt != `ST_BOOT) begin
      if (state_r.hb_cnt >= 32'(HB_CYCLES - 1)) begin
        state_nxt.hb_cnt = '0;
        state_nxt.hb_pend = 1'b1; // [RULE4]
      end else begin
        state_nxt.hb_cnt = state_r.hb_cnt + 32'h1;
      end
    end
    case (state_r.fsm)
      node_pkg::FSM_IDLE: begin
        if (!cfg_bus.valid) begin
          state_nxt.fsm = node_pkg::FSM_IDLE;
        end else if (rx_valid && rx_is_nmt) begin
          if (nmt_for_me) begin
            case (rx_data[7:0])
              `NMT_START: state_nxt.nmt = `ST_OPER;
              `NMT_STOP: state_nxt.nmt = `ST_STOPPED;
              `NMT_PREOP: state_nxt.nmt = `ST_PREOP;
              `NMT_RESET_APP, `NMT_RESET_COMM: begin
                state_nxt.nmt = `ST_BOOT;
                state_nxt.hb_pend = 1'b1;
                state_nxt.hb_cnt = '0;
              end
              default: state_nxt.nmt = state_r.nmt;
            endcase
          end
        end else if (rx_valid && rx_is_sdo && state_r.nmt != `ST_STOPPED &&
                     state_r.nmt != `ST_BOOT) begin
          state_nxt.od_index = rx_data[23:8];
          state_nxt.od_sub = rx_data[31:24];
          state_nxt.od_wdata = rx_data[63:32];
          // segmented and block requests are refused with an abort
          if (rx_ccs == `CCS_DOWNLOAD && rx_data[`EXPEDITED_BIT]) begin // [RULE6]
            state_nxt.od_write = 1'b1;
            state_nxt.fsm = node_pkg::FSM_OD;
          end else if (rx_ccs == `CCS_UPLOAD) begin
            state_nxt.od_write = 1'b0;
            state_nxt.fsm = node_pkg::FSM_OD;
          end else begin
            state_nxt.tx_id = cob(`COB_SDO_TX, cfg_bus.node_id);
            state_nxt.tx_dlc = `DLC_FULL;
            state_nxt.tx_data = sdo_frame(`SCS_ABORT, rx_data[23:8], rx_data[31:24],
                                          `ABORT_BAD_CMD); // [RULE6]
            state_nxt.kind = node_pkg::TXK_SDO;
            state_nxt.fsm = node_pkg::FSM_TX;
          end
        end else if (state_r.emcy_pend) begin
          state_nxt.tx_id = cob(`COB_EMCY, cfg_bus.node_id);
          state_nxt.tx_dlc = `DLC_FULL;
          state_nxt.tx_data = {40'h0, state_r.emcy_reg, state_r.emcy_code}; // [RULE5]
          state_nxt.kind = node_pkg::TXK_EMCY;
          state_nxt.fsm = node_pkg::FSM_TX;
        end else if (state_r.hb_pend) begin
          state_nxt.tx_id = cob(`COB_HB, cfg_bus.node_id);
          state_nxt.tx_dlc = `DLC_HB;
          state_nxt.tx_data = {56'h0, state_r.nmt}; // [RULE4]
          state_nxt.kind = node_pkg::TXK_HB;
          state_nxt.fsm = node_pkg::FSM_TX;
        end
      end
      node_pkg::FSM_OD: begin
        if (od_ack) begin
          state_nxt.tx_id = cob(`COB_SDO_TX, cfg_bus.node_id);
          state_nxt.tx_dlc = `DLC_FULL;
          state_nxt.kind = node_pkg::TXK_SDO;
          state_nxt.fsm = node_pkg::FSM_TX;
          if (od_fail) begin
            state_nxt.tx_data = sdo_frame(`SCS_ABORT, state_r.od_index, state_r.od_sub,
                                          `ABORT_BAD_CMD);
          end else if (state_r.od_write) begin
            state_nxt.tx_data = sdo_frame(`SCS_DOWNLOAD_OK, state_r.od_index,
                                          state_r.od_sub, 32'h0);
          end else begin
            state_nxt.tx_data = sdo_frame(`SCS_UPLOAD_4B, state_r.od_index,
                                          state_r.od_sub, od_rdata); // [RULE6]
          end
        end
      end
      node_pkg::FSM_TX: begin
        if (tx_ready) begin
          state_nxt.fsm = node_pkg::FSM_IDLE;
          if (state_r.kind == node_pkg::TXK_EMCY) begin
            state_nxt.emcy_pend = 1'b0;
          end
          if (state_r.kind == node_pkg::TXK_HB) begin
            state_nxt.hb_pend = 1'b0;
            // boot-up message done, enter pre-operational
            if (state_r.nmt == `ST_BOOT) begin
              state_nxt.nmt = `ST_PREOP;
            end
          end
        end
      end
      default: state_nxt.fsm = node_pkg::FSM_IDLE;
    endcase
    // a new error wins over the clear of the pending flag; latest code kept
    if (err_event) begin
      state_nxt.emcy_pend = 1'b1; // [RULE5]
      state_nxt.emcy_code = err_code;
      state_nxt.emcy_reg = err_reg;
    end
    // a timer expiry in the same cycle as a send keeps the next beat pending
    if (state_r.nmt != `ST_BOOT && state_r.hb_cnt >= 32'(HB_CYCLES - 1)) begin
      state_nxt.hb_pend = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= '0;
      state_r.hb_pend <= 1'b1;
      state_r.nmt <= `ST_BOOT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign rx_ready = (state_r.fsm == node_pkg::FSM_IDLE) && cfg_bus.valid;
  assign tx_valid = (state_r.fsm == node_pkg::FSM_TX);
  assign tx_id = state_r.tx_id;
  assign tx_dlc = state_r.tx_dlc;
  assign tx_data = state_r.tx_data;
  assign od_req = (state_r.fsm == node_pkg::FSM_OD);
  assign od_write = state_r.od_write;
  assign od_index = state_r.od_index;
  assign od_sub = state_r.od_sub;
  assign od_wdata = state_r.od_wdata;
  assign nmt_state = state_r.nmt;
  assign bit_div = state_r.bit_div;
  assign node_id = cfg_bus.node_id; // [RULE2]
  assign bit_rate_sel = cfg_bus.rate_sel; // [RULE1]
endmodule

// [canopen_node_chk.sv]
// concurrent checks on the canopen node ports
// assumes one clock domain and an async active-high reset
`timescale 1ns/1ps
module canopen_node_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] dip_sw_n,
  input wire logic [5:0] node_id,
  input wire logic [1:0] bit_rate_sel,
  input wire logic [7:0] bit_div,
  input wire logic [7:0] nmt_state,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [10:0] rx_id,
  input wire logic [3:0] rx_dlc,
  input wire logic [63:0] rx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data,
  input wire logic err_event,
  input wire logic od_req,
  input wire logic od_ack
);
  logic [1:0] cyc_r;
  logic [1:0] cyc_nxt;
  wire logic [5:0] sw_id = ~{dip_sw_n[2], dip_sw_n[3], dip_sw_n[4], dip_sw_n[5],
    dip_sw_n[6], dip_sw_n[7]};
  wire logic [1:0] sw_rate = ~{dip_sw_n[0], dip_sw_n[1]};
  // saturates at 3: cycles since reset left, enough to reach the frozen state
  assign cyc_nxt = (cyc_r == 2'h3) ? cyc_r : cyc_r + 2'h1;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cyc_r <= 2'h0;
    else cyc_r <= cyc_nxt;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // bit0 of nmt_state is set only in operational and pre-operational
  sequence sdo_bad_s;
    rx_valid && rx_ready && rx_id == 11'h600 + node_id && rx_dlc == 4'h8 && nmt_state[0]
      && rx_data[7:5] != 3'h2 && !(rx_data[7:5] == 3'h1 && rx_data[1]);
  endsequence
  sequence abort_s;
    tx_valid && tx_data[7:0] == 8'h80 && tx_data[63:32] == 32'h05040001 && !od_req;
  endsequence
  a_cfg_latch: assert property (
    cyc_r == 2'h1 |-> node_id == $past(sw_id) && bit_rate_sel == $past(sw_rate))
    else $error("config not from switches");
  a_cfg_frozen: assert property (
    cyc_r == 2'h3 |-> $stable(node_id) && $stable(bit_rate_sel) && $stable(bit_div))
    else $error("config moved");
  a_div_rate: assert property (
    cyc_r == 2'h3 |-> bit_div == (8'h50 >> bit_rate_sel)) else $error("bad divider");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_id) && $stable(tx_data))
    else $error("frame not held");
  a_tx_drop: assert property (tx_valid && tx_ready |=> !tx_valid)
    else $error("frame not dropped");
  a_hb_body: assert property (
    tx_valid && tx_id == 11'h700 + node_id |-> tx_dlc == 4'h1 && tx_data[7:0] == nmt_state)
    else $error("bad heartbeat");
  a_emcy_sent: assert property (
    err_event |-> ##[1:300] (tx_valid && tx_id == 11'h080 + node_id && tx_dlc == 4'h8))
    else $error("no emergency");
  a_sdo_abort: assert property (sdo_bad_s |=> abort_s)
    else $error("no abort");
  a_sdo_reply: assert property (
    od_req && od_ack |=> tx_valid && tx_id == 11'h580 + node_id) else $error("no reply");
endmodule
bind canopen_node canopen_node_chk chk_u (.*);

// [master_node_model.sv]
// behavioural can master facing the node's frame ports
// assumes frame inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module master_node_model (
  input wire logic sys_clk,
  input wire logic slow,
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [10:0] rx_id,
  output logic [3:0] rx_dlc,
  output logic [63:0] rx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic [3:0] tx_dlc,
  input wire logic [63:0] tx_data
);
  logic [78:0] seen_q[$];
  initial begin
    rx_valid = 1'b0;
    rx_id = 11'h0;
    rx_dlc = 4'h0;
    rx_data = 64'h0;
    tx_ready = 1'b0;
  end
  // a slow master toggles ready so that held frames get exercised
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) seen_q.push_back({tx_id, tx_dlc, tx_data});
    #1 tx_ready = !slow || !tx_ready;
  end
  // callers build expedited requests only, bar the deliberate refusals
  task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
    @(posedge sys_clk);
    #1 rx_valid = 1'b1;
    rx_id = id;
    rx_dlc = dlc;
    rx_data = data;
    while (!rx_ready) begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    // released id and data lines show the inverse, so stale data cannot pass
    #1 rx_valid = 1'b0;
    rx_id = ~id;
    rx_data = ~data;
  endtask
endmodule

// [canopen_node_config_services_tb.sv]
// self-checking bench for the canopen node
// assumes the master model and the bound checker are compiled alongside
`timescale 1ns/1ps
module canopen_node_config_services_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic slow = 1'b0;
  logic [7:0] dip_sw_n = 8'hff;
  logic err_event = 1'b0;
  logic [15:0] err_code = 16'h0;
  logic [7:0] err_reg = 8'h0;
  logic od_ack = 1'b0;
  logic od_fail = 1'b0;
  logic fail_v, ok_v;
  logic [31:0] od_rdata = 32'h0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, od_req, od_write;
  logic [10:0] rx_id, tx_id;
  logic [3:0] rx_dlc, tx_dlc;
  logic [63:0] rx_data, tx_data;
  logic [5:0] node_id, nid;
  logic [1:0] bit_rate_sel, rt;
  logic [7:0] bit_div, nmt_state, od_sub;
  logic [15:0] od_index;
  logic [31:0] od_wdata, rd_v, dat;
  logic [23:0] ixs, ec;
  logic [56:0] od_got;
  logic [78:0] fr;
  logic [7:0] cmds [8] = '{8'h40, 8'h23, 8'h2b, 8'h2f, 8'h27, 8'h21, 8'h00, 8'h60};
  integer seed = 5;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #5 sys_clk = ~sys_clk;
  canopen_node #(.HB_CYCLES(200)) dut_u (.*);
  master_node_model m_u (.*);
  // dictionary stand-in: answers one cycle after each request, sometimes failing
  always @(posedge sys_clk) begin
    #1 od_ack = od_req && !od_ack;
    od_fail = od_ack && (($random(seed) & 3) == 0);
    od_rdata = od_ack ? $random(seed) : ~od_rdata;
    if (od_ack) begin
      rd_v = od_rdata;
      fail_v = od_fail;
      od_got = {od_write, od_index, od_sub, od_wdata};
    end
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic [7:0] sw_of(input logic [1:0] r, input logic [5:0] id);
    return ~{id[0], id[1], id[2], id[3], id[4], id[5], r[0], r[1]};
  endfunction
  function automatic logic [63:0] sdo_exp(input logic ok, input logic [7:0] c);
    if (!ok || fail_v) return {32'h05040001, ixs, 8'h80};
    return c[5] ? {32'h0, ixs, 8'h60} : {rd_v, ixs, 8'h43};
  endfunction
  // wide enough for a whole frame, so the length code is compared as well
  task automatic chk_val(input logic [78:0] got, input logic [78:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // frames of other kinds are skipped, since heartbeats interleave freely
  task automatic get_frame(input logic [10:0] id);
    int n;
    n = 0;
    fr = {~id, 68'h0};
    while (n < 600 && fr[78:68] !== id) begin
      if (m_u.seen_q.size() > 0) fr = m_u.seen_q.pop_front();
      else begin
        @(posedge sys_clk);
        n++;
      end
    end
    chk_val(fr[78:68], id);
  endtask
  task automatic conclude;
    if (errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 4; i++) begin
      // inputs move just after an edge, never on it
      @(posedge sys_clk);
      #1 rt = i[1:0];
      nid = (i == 0) ? 6'h00 : (i == 3) ? 6'h3f : 6'($random(seed));
      slow = i[0];
      dip_sw_n = sw_of(rt, nid);
      rst = 1'b1;
      repeat (6) @(posedge sys_clk);
      #1 rst = 1'b0;
      // frames of the previous node must not satisfy this run's lookups
      m_u.seen_q.delete();
      @(posedge sys_clk);
      #1 dip_sw_n = 8'($random(seed));
      repeat (2) @(posedge sys_clk);
      #1 chk_val(node_id, nid);
      chk_val(bit_rate_sel, rt);
      chk_val(bit_div, 8'h50 >> rt);
      get_frame(11'h700 + nid);
      chk_val({fr[67:64], fr[7:0]}, 12'h100);
      foreach (cmds[k]) begin
        ixs = 24'($random(seed));
        dat = $random(seed);
        fail_v = 1'b0;
        ok_v = cmds[k][7:5] == 3'h2 || (cmds[k][7:5] == 3'h1 && cmds[k][1]);
        m_u.send(11'h600 + nid, 4'h8, {dat, ixs, cmds[k]});
        get_frame(11'h580 + nid);
        chk_val(fr[67:0], {4'h8, sdo_exp(ok_v, cmds[k])});
        if (ok_v) chk_val(od_got[56:32], {cmds[k][5], ixs[15:0], ixs[23:16]});
        if (cmds[k] == 8'h23) chk_val(od_got[31:0], dat);
      end
      ec = 24'($random(seed));
      @(posedge sys_clk);
      #1 err_code = ec[15:0];
      err_reg = ec[23:16];
      err_event = 1'b1;
      @(posedge sys_clk);
      #1 err_event = 1'b0;
      err_code = ~err_code;
      get_frame(11'h080 + nid);
      chk_val(fr[67:0], {4'h8, 40'h0, ec});
      m_u.send(11'h000, 4'h2, {50'h0, nid, 8'h01});
      m_u.seen_q.delete();
      chk_val(nmt_state, 8'h05);
      get_frame(11'h700 + nid);
      chk_val(fr[7:0], 8'h05);
      // node byte never zero and never ours: the command must be ignored
      m_u.send(11'h000, 4'h2, {50'h0, (nid ^ 6'h01) | 6'h02, 8'h02});
      chk_val(nmt_state, 8'h05);
      m_u.send(11'h000, 4'h2, {56'h0, 8'h02});
      chk_val(nmt_state, 8'h04);
      m_u.send(11'h000, 4'h2, {50'h0, nid, 8'h80});
      chk_val(nmt_state, 8'h7f);
      m_u.send(11'h000, 4'h2, {50'h0, nid, i[0] ? 8'h81 : 8'h82});
      m_u.seen_q.delete();
      chk_val(nmt_state, 8'h00);
      get_frame(11'h700 + nid);
      chk_val({fr[67:64], fr[7:0]}, 12'h100);
      #1 chk_val(nmt_state, 8'h7f);
    end
    conclude();
  end
endmodule
